// *** verilog/standby_ram_freeze_control_defines.svh ***
`ifndef STANDBY_RAM_FREEZE_CONTROL_DEFINES_SVH
`define STANDBY_RAM_FREEZE_CONTROL_DEFINES_SVH

// standby ram geometry: 16 Kbytes as 8k words of 16 bits
`define SRF_RAM_BYTES       16384
`define SRF_ADDR_W          13
`define SRF_DATA_W          16
// reset values
`define SRF_ENABLE_RST      1'b0
`define SRF_SEL_STANDBY     1'b1
// supervisor timing: 1 ms least reset hold after supply stable
`define SRF_CLK_MHZ         20
`define SRF_HOLD_US         1000
`define SRF_HOLD_CYCLES     (`SRF_HOLD_US * `SRF_CLK_MHZ)
`define SRF_CNT_W           15
// internal settle stretch after pin release, in core clocks
`define SRF_SETTLE_CYCLES   3
// low-voltage detector threshold, in millivolts, informational
`define SRF_LVD_MV          1000
`define SRF_DIP_MV          450

`endif

// *** verilog/standby_ram_freeze_pkg.sv ***
package standby_ram_freeze_pkg;
  // power modes of the device
  typedef enum logic [3:0] {
    MODE_RUN     = 4'b0001,
    MODE_IDLE    = 4'b0010,
    MODE_PWRDOWN = 4'b0100,
    MODE_STANDBY = 4'b1000
  } power_mode_t;
  // reset sequencer states
  typedef enum logic [3:0] {
    SEQ_RESET   = 4'b0001,
    SEQ_SETTLE  = 4'b0010,
    SEQ_FLASH   = 4'b0100,
    SEQ_RUNNING = 4'b1000
  } seq_state_t;
endpackage

// *** verilog/ram_gate.sv ***
`timescale 1ns/1ps
`include "standby_ram_freeze_control_defines.svh"
// output gating stage on the switched ram supply: blocks strobe and address
module ram_gate
  import standby_ram_freeze_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire logic                   freeze,
  input  wire logic                   core_we_n,
  input  wire logic                   core_ce_n,
  input  wire logic [`SRF_ADDR_W-1:0] core_addr,
  input  wire logic [`SRF_DATA_W-1:0] core_wdata,
  output logic                        ram_we_n_q,
  output logic                        ram_ce_n_q,
  output logic [`SRF_ADDR_W-1:0]      ram_addr_q,
  output logic [`SRF_DATA_W-1:0]      ram_wdata_q
);
  // frozen: strobes forced inactive, address parked at zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ram_we_n_q  <= 1'b1;
      ram_ce_n_q  <= 1'b1;
      ram_addr_q  <= '0;
      ram_wdata_q <= '0;
    end else if (freeze) begin
      ram_we_n_q  <= 1'b1;
      ram_ce_n_q  <= 1'b1;
      ram_addr_q  <= '0;
      ram_wdata_q <= '0;
    end else begin
      ram_we_n_q  <= core_we_n;
      ram_ce_n_q  <= core_ce_n;
      ram_addr_q  <= core_addr;
      ram_wdata_q <= core_wdata;
    end
  end

  gate_blocks_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    freeze |=> (ram_we_n_q && ram_ce_n_q && ram_addr_q == '0))
    else $error("strobe passed while frozen");
endmodule

// *** verilog/standby_ram_freeze_control.sv ***
`timescale 1ns/1ps
`include "standby_ram_freeze_control_defines.svh"
// Contract
// - clearing the standby ram enable freezes the ram interface at once.
// - any reset event clears the standby ram enable.
// - a reset event selects the standby core reference as ram supply.
// - the ram stays frozen until software sets the enable after reset.
// - while the main core supply is down the ram is frozen regardless.
// - with enable set, a brief core supply dip causes no freeze.
// - a gating stage blocks write strobe and address during power-off.
// - the low-voltage detector holds reset until the core supply is up.
// - flash initialization starts when reset_input_n is released.
// - internal reset release returns ram supply to the main core supply.
// - idle stops cpu, power-down stops cpu and peripherals, standby biases
//          only the standby ram.
// - the standby region is 16 Kbytes on its own low-power regulator.
module standby_ram_freeze_control
  import standby_ram_freeze_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire logic                   reset_input_n,
  input  wire logic                   low_voltage_detector,
  input  wire logic                   main_core_supply_ok,
  input  wire logic                   core_dip,
  input  wire logic                   enable_set,
  input  wire logic                   enable_clear,
  input  wire logic [1:0]             mode_req,
  input  wire logic                   rtc_keep,
  input  wire logic                   core_we_n,
  input  wire logic                   core_ce_n,
  input  wire logic [`SRF_ADDR_W-1:0] core_addr,
  input  wire logic [`SRF_DATA_W-1:0] core_wdata,
  output logic                        standby_ram_enable_q,
  output logic                        ram_freeze_q,
  output logic                        sel_standby_ref_q,
  output logic                        internal_reset_q,
  output logic                        flash_init_start_q,
  output logic                        cpu_clk_en_q,
  output logic                        periph_clk_en_q,
  output logic                        rtc_clk_en_q,
  output logic                        ext_ram_power_q,
  output logic                        ram_we_n_q,
  output logic                        ram_ce_n_q,
  output logic [`SRF_ADDR_W-1:0]      ram_addr_q,
  output logic [`SRF_DATA_W-1:0]      ram_wdata_q
);
  // pin-level inputs through two flops; stage one feeds stage two only
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {reset_input_n, low_voltage_detector,
                  main_core_supply_ok, core_dip};
      sync2_q <= sync1_q;
    end
  end
  logic reset_input_n_s;
  logic lvd_s;
  logic supply_s;
  logic dip_s;
  assign reset_input_n_s  = sync2_q[3];
  assign lvd_s    = sync2_q[2];
  assign supply_s = sync2_q[1];
  assign dip_s    = sync2_q[0];

  // any reset source: pin low or detector still holding the core
  logic reset_event;
  assign reset_event = !reset_input_n_s || lvd_s;

  // rising edge of the released pin starts flash init
  logic reset_input_n_d1_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_input_n_d1_q <= 1'b0;
    end else begin
      reset_input_n_d1_q <= reset_input_n_s;
    end
  end

  // reset sequencer; a settle stage covers the regulator after release
  seq_state_t state_q;
  logic [`SRF_CNT_W-1:0] settle_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SEQ_RESET;
    end else if (reset_event) begin
      state_q <= SEQ_RESET;
    end else begin
      unique case (state_q)
        SEQ_RESET:   state_q <= SEQ_FLASH;
        SEQ_FLASH:   state_q <= SEQ_SETTLE;
        SEQ_SETTLE:  if (settle_q == '0) state_q <= SEQ_RUNNING;
        SEQ_RUNNING: state_q <= SEQ_RUNNING;
        default:     state_q <= SEQ_RESET;
      endcase
    end
  end

  // short internal stretch so flash init sees release before the core runs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_q <= '0;
    end else if (state_q == SEQ_FLASH) begin
      settle_q <= `SRF_CNT_W'(`SRF_SETTLE_CYCLES);
    end else if (settle_q != '0) begin
      settle_q <= settle_q - 1'b1;
    end
  end

  // one-cycle pulse at pin release; the pin hold is the supervisor's job
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_init_start_q <= 1'b0;
    end else begin
      flash_init_start_q <= reset_input_n_s && !reset_input_n_d1_q && !lvd_s;
    end
  end

  // internal reset is held through all states before running
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      internal_reset_q <= 1'b1;
    end else begin
      internal_reset_q <= reset_event || (state_q != SEQ_RUNNING);
    end
  end

  // enable bit: reset clears it, software sets it once running
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      standby_ram_enable_q <= `SRF_ENABLE_RST;
    end else if (reset_event || !supply_s) begin
      standby_ram_enable_q <= 1'b0;
    end else if (state_q == SEQ_RUNNING && enable_set) begin
      standby_ram_enable_q <= 1'b1;
    end else if (enable_clear) begin
      standby_ram_enable_q <= 1'b0;
    end
  end

  // supply select: standby reference under reset, main once released
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_standby_ref_q <= `SRF_SEL_STANDBY;
    end else if (reset_event || !supply_s) begin
      sel_standby_ref_q <= 1'b1;
    end else if (!internal_reset_q) begin
      sel_standby_ref_q <= 1'b0;
    end
  end

  // standby detect ignores dips while enabled; a collapse always counts
  logic standby_detect;
  assign standby_detect = !supply_s ||
                          (dip_s && !standby_ram_enable_q);

  // registered so no edge of the enable, standby detect or enable_clear can glitch the freeze
  logic freeze_d;
  assign freeze_d = !standby_ram_enable_q || standby_detect ||
                    enable_clear;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ram_freeze_q <= 1'b1;
    end else begin
      ram_freeze_q <= freeze_d;
    end
  end

  // power mode clock gating; only the cpu clock enable also waits for running
  power_mode_t mode;
  always_comb begin
    unique case (mode_req)
      2'd1:    mode = MODE_IDLE;
      2'd2:    mode = MODE_PWRDOWN;
      2'd3:    mode = MODE_STANDBY;
      default: mode = MODE_RUN;
    endcase
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_clk_en_q    <= 1'b0;
      periph_clk_en_q <= 1'b0;
      rtc_clk_en_q    <= 1'b0;
      ext_ram_power_q <= 1'b1;
    end else begin
      cpu_clk_en_q    <= (mode == MODE_RUN) && !internal_reset_q;
      periph_clk_en_q <= (mode inside {MODE_RUN, MODE_IDLE});
      rtc_clk_en_q    <= (mode != MODE_STANDBY) && rtc_keep;
      ext_ram_power_q <= (mode != MODE_STANDBY) && supply_s;
    end
  end

  // gating stage on the switched supply
  ram_gate u_gate (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .freeze      (ram_freeze_q),
    .core_we_n   (core_we_n),
    .core_ce_n   (core_ce_n),
    .core_addr   (core_addr),
    .core_wdata  (core_wdata),
    .ram_we_n_q  (ram_we_n_q),
    .ram_ce_n_q  (ram_ce_n_q),
    .ram_addr_q  (ram_addr_q),
    .ram_wdata_q (ram_wdata_q)
  );

  // checks
  sequence s_released;
    !reset_event && supply_s;
  endsequence

  reset_clears_en_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reset_event |=> !standby_ram_enable_q)
    else $error("enable survived reset");
  reset_sel_ref_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reset_event |=> sel_standby_ref_q)
    else $error("standby reference not selected");
  clear_freezes_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    enable_clear |=> ram_freeze_q)
    else $error("clear did not freeze");
  disabled_frozen_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !standby_ram_enable_q |=> ram_freeze_q)
    else $error("unfrozen without enable");
  collapse_freezes_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    !supply_s |=> ram_freeze_q ##1 ram_freeze_q)
    else $error("collapse left ram open");
  dip_ignored_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (standby_ram_enable_q && supply_s && !enable_clear && !reset_event)
    |=> !ram_freeze_q)
    else $error("dip froze enabled ram");
  lvd_holds_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    lvd_s |=> internal_reset_q)
    else $error("reset released under detector");
  main_supply_back_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    s_released ##1 (s_released and !internal_reset_q)
    |=> !sel_standby_ref_q)
    else $error("supply not returned to main");
  flash_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    flash_init_start_q |-> $past(reset_input_n_s) && !$past(reset_input_n_d1_q))
    else $error("flash start without release");
  standby_mode_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode == MODE_STANDBY |=> !ext_ram_power_q && !cpu_clk_en_q)
    else $error("standby left ram powered");
endmodule

// *** bench/supply_supervisor_model.sv ***
`timescale 1ns/1ps
// supply ramp and reset supervisor standing on the far side of the block
module supply_supervisor_model #(
  parameter int HOLD_CYCLES = 20,
  parameter int LVD_CYCLES  = 4
) (
  input  wire logic core_clk,
  input  wire logic supply_on,
  input  wire logic dip_req,
  output logic      reset_input_n,
  output logic      low_voltage_detector,
  output logic      main_core_supply_ok,
  output logic      core_dip
);
  int ramp_q = 0;

  // ramp counter restarts whenever the main supply is off
  always_ff @(posedge core_clk) begin
    if (!supply_on) begin
      ramp_q <= 0;
    end else if (ramp_q < LVD_CYCLES + HOLD_CYCLES) begin
      ramp_q <= ramp_q + 1;
    end
  end

  // pin falls with the supply and stays low, glitch free, past the hold
  assign reset_input_n = supply_on &&
                         (ramp_q >= LVD_CYCLES + HOLD_CYCLES);
  // detector high until the core supply has ramped up
  assign low_voltage_detector = !supply_on || (ramp_q < LVD_CYCLES);
  assign main_core_supply_ok  = supply_on && (ramp_q >= LVD_CYCLES);
  assign core_dip             = dip_req;
endmodule

// *** bench/standby_ram_freeze_control_bench.sv ***
`timescale 1ns/1ps
`include "standby_ram_freeze_control_defines.svh"
module standby_ram_freeze_control_bench;
  import standby_ram_freeze_pkg::*;
  logic core_clk = 1'b0, rst_n = 1'b0, supply_on = 1'b0, dip_req = 1'b0;
  logic enable_set = 1'b0, enable_clear = 1'b0, rtc_keep = 1'b1;
  logic [1:0] mode_req = 2'b00;
  logic core_we_n = 1'b1, core_ce_n = 1'b1;
  logic [`SRF_ADDR_W-1:0] core_addr = '0;
  logic [`SRF_DATA_W-1:0] core_wdata = '0;
  logic reset_input_n, low_voltage_detector, main_core_supply_ok, core_dip;
  logic standby_ram_enable_q, ram_freeze_q, sel_standby_ref_q;
  logic internal_reset_q, flash_init_start_q, cpu_clk_en_q;
  logic periph_clk_en_q, rtc_clk_en_q, ext_ram_power_q, ram_we_n_q, ram_ce_n_q;
  logic [`SRF_ADDR_W-1:0] ram_addr_q;
  logic [`SRF_DATA_W-1:0] ram_wdata_q;
  int fail_count = 0, samples_checked = 0, flash_cnt = 0, flash_early = 0;

  supply_supervisor_model #(.HOLD_CYCLES(20), .LVD_CYCLES(4)) u_sup (
    .core_clk(core_clk), .supply_on(supply_on), .dip_req(dip_req),
    .reset_input_n(reset_input_n), .low_voltage_detector(low_voltage_detector),
    .main_core_supply_ok(main_core_supply_ok), .core_dip(core_dip));

  standby_ram_freeze_control u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .reset_input_n(reset_input_n),
    .low_voltage_detector(low_voltage_detector),
    .main_core_supply_ok(main_core_supply_ok), .core_dip(core_dip),
    .enable_set(enable_set), .enable_clear(enable_clear),
    .mode_req(mode_req), .rtc_keep(rtc_keep), .core_we_n(core_we_n),
    .core_ce_n(core_ce_n), .core_addr(core_addr), .core_wdata(core_wdata),
    .standby_ram_enable_q(standby_ram_enable_q), .ram_freeze_q(ram_freeze_q),
    .sel_standby_ref_q(sel_standby_ref_q), .internal_reset_q(internal_reset_q),
    .flash_init_start_q(flash_init_start_q), .cpu_clk_en_q(cpu_clk_en_q),
    .periph_clk_en_q(periph_clk_en_q), .rtc_clk_en_q(rtc_clk_en_q),
    .ext_ram_power_q(ext_ram_power_q), .ram_we_n_q(ram_we_n_q),
    .ram_ce_n_q(ram_ce_n_q), .ram_addr_q(ram_addr_q),
    .ram_wdata_q(ram_wdata_q));

  // 20 MHz core clock
  initial begin
    forever #25 core_clk = ~core_clk;
  end

  // counts flash start pulses, and any seen while the pin is still low
  always @(posedge core_clk) begin
    if (flash_init_start_q === 1'b1) begin
      flash_cnt++;
      if (reset_input_n !== 1'b1) flash_early++;
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // inputs always land a fixed 2 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask

  task automatic pulse(ref logic sig);
    sig = 1'b1;
    tick(1);
    sig = 1'b0;
    tick(2);
  endtask

  task automatic power_up(input int pulses);
    supply_on = 1'b1;
    tick(4);
    check(internal_reset_q, 1'b1);
    tick(18);
    check(internal_reset_q, 1'b1);
    for (int i = 0; i < 100 && internal_reset_q !== 1'b0; i++) tick(1);
    tick(2);
    check(internal_reset_q, 1'b0);
    check(sel_standby_ref_q, 1'b0);
    check(standby_ram_enable_q, 1'b0);
    check(ram_freeze_q, 1'b1);
    check(flash_cnt, pulses);
    check(flash_early, 0);
  endtask

  task automatic enable_and_access;
    pulse(enable_set);
    check(standby_ram_enable_q, 1'b1);
    check(ram_freeze_q, 1'b0);
    core_we_n = 1'b0;
    core_ce_n = 1'b0;
    core_addr = 13'h0abc;
    core_wdata = 16'h5a5a;
    tick(2);
    check(ram_we_n_q, 1'b0);
    check(ram_addr_q, 16'h0abc);
    check(ram_wdata_q, 16'h5a5a);
  endtask

  task automatic dip_while_enabled;
    dip_req = 1'b1;
    for (int i = 0; i < 6; i++) begin
      tick(1);
      check(ram_freeze_q, 1'b0);
    end
    dip_req = 1'b0;
    tick(2);
  endtask

  task automatic clear_freezes;
    enable_clear = 1'b1;
    tick(1);
    enable_clear = 1'b0;
    check(ram_freeze_q, 1'b1);
    tick(2);
    check(standby_ram_enable_q, 1'b0);
    check(ram_we_n_q, 1'b1);
    check(ram_ce_n_q, 1'b1);
    check(ram_addr_q, 16'h0000);
  endtask

  task automatic supply_loss;
    supply_on = 1'b0;
    tick(4);
    check(ram_freeze_q, 1'b1);
    pulse(enable_set);
    check(ram_freeze_q, 1'b1);
    check(standby_ram_enable_q, 1'b0);
    check(sel_standby_ref_q, 1'b1);
    check(internal_reset_q, 1'b1);
    check(ram_we_n_q, 1'b1);
  endtask

  task automatic modes;
    logic [3:0] cpu_exp, per_exp;
    cpu_exp = 4'b0001;
    per_exp = 4'b0011;
    for (int m = 0; m < 4; m++) begin
      mode_req = 2'(m);
      tick(4);
      check(cpu_clk_en_q, cpu_exp[m]);
      check(periph_clk_en_q, per_exp[m]);
      check(rtc_clk_en_q, m != 3);
      check(ext_ram_power_q, m != 3);
    end
    // idle without the rtc kept: peripherals run, rtc stops
    mode_req = 2'b01;
    rtc_keep = 1'b0;
    tick(4);
    check(rtc_clk_en_q, 1'b0);
    check(periph_clk_en_q, 1'b1);
    rtc_keep = 1'b1;
    mode_req = 2'b00;
    tick(4);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // watchdog: the sequence needs well under 1000 cycles
  initial begin
    #(5000 * 50);
    fail_count++;
    final_report();
  end

  initial begin
    tick(3);
    rst_n = 1'b1;
    power_up(1);
    enable_and_access();
    dip_while_enabled();
    clear_freezes();
    enable_and_access();
    supply_loss();
    core_we_n = 1'b1;
    core_ce_n = 1'b1;
    power_up(2);
    modes();
    enable_and_access();
    final_report();
  end
endmodule
